// ---- dv/async_serial_core_fracbaud_tb.sv ----
`default_nettype none
module async_serial_core_fracbaud_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        core_clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic [7:0]  reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   logic        rx_line;
   logic        tx_line;
   logic        busy;
   logic [31:0] rd;
   logic [21:0] dv;
   logic [7:0]  b;
   logic [7:0]  sent[4];
   int          n_fail = 0;
   int          n_tests = 0;
   int          lw;
   int          ll;
   initial forever #2 core_clk = ~core_clk;
   serial_core i_serial_core (
      .core_clk            (core_clk),
      .sys_rst             (sys_rst),
      .reg_addr            (reg_addr),
      .reg_wdata           (reg_wdata),
      .reg_wr              (reg_wr),
      .reg_rd              (reg_rd),
      .reg_rdata           (reg_rdata),
      .port0_serial_input  (rx_line),
      .port0_serial_output (tx_line),
      .busy                (busy)
   );
   serial_partner i_serial_partner (
      .core_clk (core_clk),
      .line_in  (tx_line),
      .line_out (rx_line)
   );
   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rdr(input logic [7:0] a, output logic [31:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task automatic wait_idle;
      int k;
      k = 0;
      repeat (2) @(posedge core_clk);
      #1;
      while (busy !== 1'b0 && k < 20000) begin
         @(posedge core_clk);
         #1;
         k++;
      end
      if (k >= 20000) begin
         n_fail++;
         $display("CHECK FAILED busy timeout expected 0 seen 1");
         end_of_test();
      end
   endtask
   // mode change with the module stopped first
   task automatic setup(input logic [31:0] line);
      wr(serial_pkg::ADDR_CTRL, 32'h300);
      wr(serial_pkg::ADDR_LINE, line);
      wr(serial_pkg::ADDR_CTRL, 32'h301);
   endtask
   task automatic rx_chk(input logic [7:0] v, input int par,
                         input logic stp, input logic [31:0] exp);
      i_serial_partner.send(v, par, stp);
      rdr(serial_pkg::ADDR_DATA, rd);
      chk("rx word", exp, rd);
   endtask
   // divisor as 16.6 fixed point, fraction rounded to nearest
   function automatic logic [21:0] brd(input real baud);
      real d;
      d = 250.0e6 / (16.0 * baud);
      return {16'($rtoi(d)), 6'($rtoi((d - $floor(d)) * 64.0 + 0.5))};
   endfunction
   // nine low bits: start plus a zero byte
   function automatic int low_len(input logic [21:0] v);
      return (144 * (int'(v[21:6]) * 64 + int'(v[5:0]))) / 64;
   endfunction
   initial begin
      void'($urandom(32'h5670151b));
      repeat (16) @(posedge core_clk);
      sys_rst <= 1'b0;
      @(posedge core_clk);
      #1;
      chk("idle line", 32'h1, {31'h0, tx_line});
      chk("busy", 32'h0, {31'h0, busy});
      rdr(serial_pkg::ADDR_CTRL, rd);
      chk("ctrl", {16'h0, serial_pkg::CTRL_RESET}, rd);
      rdr(serial_pkg::ADDR_FLAG, rd);
      chk("flags", 32'h90, rd);
      rdr(8'h3c, rd);
      chk("unmapped", 32'h0, rd);
      $display("reset test done");
      wr(serial_pkg::ADDR_IDIV, 32'h2);
      wr(serial_pkg::ADDR_FDIV, 32'h0);
      setup(32'h70);
      for (int i = 0; i < 4; i++) begin
         sent[i] = (i == 0) ? 8'h01 : 8'($urandom);
         wr(serial_pkg::ADDR_DATA, {24'h0, sent[i]});
      end
      #1 chk("busy", 32'h1, {31'h0, busy});
      wait_idle();
      chk("count", 32'd4, 32'(i_serial_partner.got_q.size()));
      foreach (sent[i])
         chk("tx", {24'h0, sent[i]}, {24'h0, i_serial_partner.got_q[i]});
      i_serial_partner.got_q.delete();
      wr(serial_pkg::ADDR_DATA, 32'ha5);
      repeat (100) @(posedge core_clk);
      wr(serial_pkg::ADDR_CTRL, 32'h300);
      #1 chk("busy off", 32'h1, {31'h0, busy});
      wait_idle();
      chk("tail", 32'ha5, {24'h0, i_serial_partner.got_q[0]});
      $display("transmit test done");
      dv = brd(4000000.0);
      wr(serial_pkg::ADDR_CTRL, 32'h300);
      wr(serial_pkg::ADDR_IDIV, {16'h0, dv[21:6]});
      wr(serial_pkg::ADDR_FDIV, {26'h0, dv[5:0]});
      wr(serial_pkg::ADDR_CTRL, 32'h301);
      wr(serial_pkg::ADDR_DATA, 32'h0);
      wait_idle();
      chk("old period", 32'd288, 32'(i_serial_partner.last_low));
      setup(32'h70);
      i_serial_partner.bit_clks = 62;
      wr(serial_pkg::ADDR_DATA, 32'h0);
      wait_idle();
      lw = low_len(dv);
      ll = i_serial_partner.last_low;
      chk("new period", 1, 32'(ll >= lw - 2 && ll <= lw + 2));
      i_serial_partner.got_q.delete();
      $display("divisor test done");
      setup(32'h76);
      for (int i = 0; i < 4; i++) begin
         b = 8'($urandom);
         rx_chk(b, 1, 1'b1, {24'h0, b});
      end
      rx_chk(8'h3c, 2, 1'b1, 32'h23c);
      rx_chk(8'hc3, 1, 1'b0, 32'h1c3);
      @(posedge core_clk);
      i_serial_partner.drive(1'b0, 62 * 12);
      i_serial_partner.drive(1'b1, 62 * 2);
      rdr(serial_pkg::ADDR_DATA, rd);
      chk("break", 32'h400, rd);
      // about three ticks low, well short of mid-bit
      i_serial_partner.drive(1'b0, 12);
      i_serial_partner.drive(1'b1, 62 * 12);
      rdr(serial_pkg::ADDR_FLAG, rd);
      chk("glitch", 1, 32'(rd[serial_pkg::FLAG_RXFE_POS]));
      $display("receive test done");
      wr(serial_pkg::ADDR_CTRL, 32'h300);
      for (int i = 0; i < 17; i++) wr(serial_pkg::ADDR_DATA, 32'(i));
      rdr(serial_pkg::ADDR_FLAG, rd);
      chk("tx full", 1, 32'(rd[serial_pkg::FLAG_TXFF_POS]));
      wr(serial_pkg::ADDR_CTRL, 32'h301);
      wait_idle();
      chk("depth", 32'd16, 32'(i_serial_partner.got_q.size()));
      setup(32'h66);
      i_serial_partner.send(8'h5a, 1, 1'b1);
      rdr(serial_pkg::ADDR_FLAG, rd);
      chk("one deep", 1, 32'(rd[serial_pkg::FLAG_RXFF_POS]));
      rdr(serial_pkg::ADDR_DATA, rd);
      chk("one deep word", 32'h5a, rd);
      wr(serial_pkg::ADDR_CTRL, 32'h300);
      wr(serial_pkg::ADDR_CTRL, 32'h303);
      repeat (4) @(posedge core_clk);
      #1 chk("ir idle", 32'h0, {31'h0, tx_line});
      $display("queue and infrared test done");
      end_of_test();
   end
endmodule // async_serial_core_fracbaud_tb
`default_nettype wire

// ---- dv/serial_partner.sv ----
`default_nettype none
module serial_partner (
   input  wire logic core_clk,
   input  wire logic line_in,
   output var logic  line_out
);
   timeunit 1ns;
   timeprecision 1ps;
   int         bit_clks = 32;
   int         low_run = 0;
   int         last_low = 0;
   logic [7:0] got_q[$];
   initial line_out = 1'b1;
   task automatic drive(input logic v, input int n);
      line_out <= v;
      repeat (n) @(posedge core_clk);
   endtask
   // par 0 none, 1 even, 2 wrong parity on purpose
   task automatic send(input logic [7:0] b, input int par,
                       input logic stp);
      @(posedge core_clk);
      drive(1'b0, bit_clks);
      for (int i = 0; i < 8; i++) drive(b[i], bit_clks);
      if (par != 0) drive((^b) ^ (par == 2), bit_clks);
      drive(stp, bit_clks);
      drive(1'b1, bit_clks);
   endtask
   // low run length times the design's bit period
   always @(posedge core_clk) begin
      if (line_in === 1'b0) low_run <= low_run + 1;
      else begin
         if (low_run != 0) last_low <= low_run;
         low_run <= 0;
      end
   end
   // parity and stop are skipped, only data is kept
   initial begin : rx_side
      logic [7:0] b;
      forever begin
         @(negedge line_in);
         repeat (bit_clks / 2) @(posedge core_clk);
         for (int i = 0; i < 8; i++) begin
            repeat (bit_clks) @(posedge core_clk);
            b[i] = line_in;
         end
         got_q.push_back(b);
         repeat (bit_clks) @(posedge core_clk);
      end
   end
endmodule // serial_partner
`default_nettype wire

// ---- hdl/serial_baud.sv ----
`default_nettype none
module serial_baud (
   input  wire logic        core_clk,
   input  wire logic        sys_rst,
   input  wire logic [15:0] div_int,
   input  wire logic [5:0]  div_frac,
   output logic             tick
);
   // fractional accumulator: period is div_int or div_int+1 clocks
   logic [15:0] cnt_reg;
   logic [6:0]  acc_reg;
   logic [6:0]  acc_sum;
   logic [15:0] limit;

   assign acc_sum = {1'b0, acc_reg[5:0]} + {1'b0, div_frac};
   assign limit   = acc_sum[6] ? div_int : div_int - 16'h0001;

   always_ff @(posedge core_clk) begin
      if (sys_rst || div_int == '0) begin
         cnt_reg <= '0;
         acc_reg <= '0;
         tick    <= 1'b0;
      end else if (cnt_reg >= limit) begin
         cnt_reg <= '0;
         acc_reg <= acc_sum;
         tick    <= 1'b1;
      end else begin
         cnt_reg <= cnt_reg + 16'h0001;
         tick    <= 1'b0;
      end
   end
endmodule // serial_baud
`default_nettype wire

// ---- hdl/serial_core.sv ----
// Behaviour
// - transmit and receive enabled after reset
// - disable finishes current character first
// - frame: start, data LSB first, parity, stop
// - receive status stored with each character
// - divisor is 16-bit integer, 6-bit fraction
// - tick at sixteen times baud rate
// - divisor and line latched on line write
// - sixteen-entry queues, receive entries twelve bits
// - enabled transmit sends until queue empty
// - busy until queue empty and stop sent
// - start bit checked at eighth tick
// - data sampled every sixteenth tick
// - stop sample low means framing error (not set here when break is flagged)
// - port-zero pins default to serial function
// - control bit selects infrared encoding
// - queues one deep until line FEN bit set
// - data read twelve bits, write eight
//
// Implementation choices: the register addresses and strobed register access.
`default_nettype none
module serial_core #(
   parameter int DEPTH = serial_pkg::FIFO_DEPTH
) (
   input  wire logic        core_clk,
   input  wire logic        sys_rst,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [31:0] reg_rdata,
   input  wire logic        port0_serial_input,
   output logic             port0_serial_output,
   output logic             busy
);
   initial begin
      if (DEPTH != 16) $error("queue depth must be 16");
   end

   typedef enum logic [4:0] {
      TX_IDLE = 5'b00001, TX_START = 5'b00010, TX_DATA = 5'b00100,
      TX_PAR  = 5'b01000, TX_STOP  = 5'b10000
   } tx_state_t;
   typedef enum logic [4:0] {
      RX_IDLE = 5'b00001, RX_START = 5'b00010, RX_DATA = 5'b00100,
      RX_PAR  = 5'b01000, RX_STOP  = 5'b10000
   } rx_state_t;

   logic [15:0] ctrl_reg;
   logic [15:0] idiv_reg;
   logic [5:0]  fdiv_reg;
   logic [29:0] active_reg;  // line[29:22] frac[21:16] int[15:0]
   logic [7:0]  line;
   logic        tick;
   logic        enable;

   assign line   = active_reg[29:22];
   assign enable = ctrl_reg[serial_pkg::CTRL_EN_POS];

   // register writes; control resets with both directions on
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         ctrl_reg   <= serial_pkg::CTRL_RESET;
         idiv_reg   <= serial_pkg::IDIV_RESET;
         fdiv_reg   <= serial_pkg::FDIV_RESET;
         active_reg <= {serial_pkg::LINE_RESET, serial_pkg::FDIV_RESET,
                        serial_pkg::IDIV_RESET};
      end else if (reg_wr) begin
         unique case (reg_addr)
            serial_pkg::ADDR_CTRL: ctrl_reg <= reg_wdata[15:0];
            serial_pkg::ADDR_IDIV: idiv_reg <= reg_wdata[15:0];
            serial_pkg::ADDR_FDIV: fdiv_reg <= reg_wdata[5:0];
            // divisor takes effect only here
            serial_pkg::ADDR_LINE: active_reg <= {reg_wdata[7:0],
                                   fdiv_reg, idiv_reg};
            default: ;
         endcase
      end
   end

   serial_baud u_baud (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .div_int  (active_reg[15:0]),
      .div_frac (active_reg[21:16]),
      .tick     (tick)
   );

   // ---------------- transmit ----------------
   logic [7:0] tx_q_data;
   logic       tx_q_empty;
   logic       tx_q_full;
   logic       tx_pop;
   tx_state_t  tx_state_reg;
   logic [7:0] tx_shift_reg;
   logic [3:0] tx_tick_reg;
   logic [2:0] tx_bit_reg;
   logic       tx_stop2_reg;
   logic       tx_par_reg;
   logic       tx_line_reg;
   logic [3:0] tx_ir_reg;
   logic [2:0] wlen_max;
   logic       par_bit;

   assign wlen_max = {1'b1, line[serial_pkg::LINE_WLEN_LSB +: 2]};
   // 5..8 bits: top index 4..7

   serial_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_txq (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .deep     (line[serial_pkg::LINE_FEN_POS]),
      .push     (reg_wr && reg_addr == serial_pkg::ADDR_DATA),
      .wdata    (reg_wdata[7:0]),
      .pop      (tx_pop),
      .rdata    (tx_q_data),
      .empty    (tx_q_empty),
      .full     (tx_q_full)
   );

   assign tx_pop = tick && tx_state_reg == TX_IDLE && !tx_q_empty
                   && enable && ctrl_reg[serial_pkg::CTRL_TXE_POS];

   // stick parity forces the bit; otherwise even/odd over data,
   // last data bit still in the shifter when the parity bit is set
   always_comb begin
      if (line[serial_pkg::LINE_SPS_POS])
         par_bit = !line[serial_pkg::LINE_EPS_POS];
      else
         par_bit = tx_par_reg ^ tx_shift_reg[0] ^
                   !line[serial_pkg::LINE_EPS_POS];
   end

   // once started, a frame runs out regardless of enable
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         tx_state_reg <= TX_IDLE;
         tx_shift_reg <= '0;
         tx_tick_reg  <= '0;
         tx_bit_reg   <= '0;
         tx_stop2_reg <= 1'b0;
         tx_par_reg   <= 1'b0;
         tx_line_reg  <= 1'b1;
      end else if (tick) begin
         tx_tick_reg <= tx_tick_reg + 4'h1;
         unique case (tx_state_reg)
            TX_IDLE: begin
               tx_tick_reg <= '0;
               tx_line_reg <= !line[serial_pkg::LINE_BRK_POS];
               if (tx_pop) begin
                  tx_shift_reg <= tx_q_data;
                  tx_par_reg   <= 1'b0;
                  tx_bit_reg   <= '0;
                  tx_line_reg  <= 1'b0;
                  tx_state_reg <= TX_START;
               end
            end
            TX_START: if (tx_tick_reg == serial_pkg::OVERSAMPLE) begin
               tx_line_reg  <= tx_shift_reg[0];
               tx_state_reg <= TX_DATA;
            end
            TX_DATA: if (tx_tick_reg == serial_pkg::OVERSAMPLE) begin
               tx_par_reg   <= tx_par_reg ^ tx_shift_reg[0];
               tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
               tx_bit_reg   <= tx_bit_reg + 3'h1;
               if (tx_bit_reg == wlen_max) begin
                  if (line[serial_pkg::LINE_PEN_POS]) begin
                     tx_line_reg  <= par_bit;
                     tx_state_reg <= TX_PAR;
                  end else begin
                     tx_line_reg  <= 1'b1;
                     tx_stop2_reg <= line[serial_pkg::LINE_STP2_POS];
                     tx_state_reg <= TX_STOP;
                  end
               end else begin
                  tx_line_reg <= tx_shift_reg[1];
               end
            end
            TX_PAR: if (tx_tick_reg == serial_pkg::OVERSAMPLE) begin
               tx_line_reg  <= 1'b1;
               tx_stop2_reg <= line[serial_pkg::LINE_STP2_POS];
               tx_state_reg <= TX_STOP;
            end
            TX_STOP: if (tx_tick_reg == serial_pkg::OVERSAMPLE) begin
               tx_stop2_reg <= 1'b0;
               if (!tx_stop2_reg) tx_state_reg <= TX_IDLE;
            end
         endcase
      end
   end

   // infrared: short high pulse for each zero bit, low otherwise
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         tx_ir_reg           <= '0;
         port0_serial_output <= 1'b1;
      end else begin
         if (ctrl_reg[serial_pkg::CTRL_IR_POS])
            port0_serial_output <= !tx_line_reg &&
                                   tx_tick_reg < serial_pkg::IR_TICKS;
         else
            port0_serial_output <= tx_line_reg;
         tx_ir_reg <= tx_tick_reg;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) busy <= 1'b0;
      else busy <= !tx_q_empty || tx_state_reg != TX_IDLE ||
                   (reg_wr && reg_addr == serial_pkg::ADDR_DATA);
   end

   // ---------------- receive ----------------
   logic [2:0]  rx_sync_reg;
   logic        rx_in_reg;
   logic        rx_raw;
   rx_state_t   rx_state_reg;
   logic [3:0]  rx_tick_reg;
   logic [2:0]  rx_bit_reg;
   logic [7:0]  rx_shift_reg;
   logic        rx_par_reg;
   logic        rx_pe_reg;
   logic        rx_low_reg;
   logic        rx_push;
   logic [11:0] rx_entry;
   logic [11:0] rx_q_data;
   logic        rx_q_empty;
   logic        rx_q_full;
   logic        rx_pop;
   logic        rx_fe;
   logic        rx_be;
   logic        rx_armed_reg;

   // raw input feeds the receiver; no infrared decoding
   assign rx_raw = port0_serial_input;

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         rx_sync_reg <= 3'b111;
         rx_in_reg   <= 1'b1;
      end else begin
         rx_sync_reg <= {rx_sync_reg[1:0], rx_raw};
         if (rx_sync_reg[1] == rx_sync_reg[2]) rx_in_reg <= rx_sync_reg[2];
      end
   end

   // a start needs a high line first: a low stop or break tail
   // must not restart the receiver
   always_ff @(posedge core_clk) begin
      if (sys_rst) rx_armed_reg <= 1'b1;
      else if (rx_state_reg != RX_IDLE) rx_armed_reg <= 1'b0;
      else if (rx_in_reg) rx_armed_reg <= 1'b1;
   end

   assign rx_fe = !rx_in_reg;
   // low through every bit and stop means break
   assign rx_be = rx_low_reg && !rx_in_reg;
   assign rx_push = tick && rx_state_reg == RX_STOP &&
                    rx_tick_reg == serial_pkg::OVERSAMPLE && !rx_q_full;
   assign rx_entry = {rx_q_full, rx_be, rx_pe_reg, rx_fe && !rx_be,
                      rx_shift_reg};
   assign rx_pop = reg_rd && reg_addr == serial_pkg::ADDR_DATA;

   logic       ovr_reg;
   always_ff @(posedge core_clk) begin
      if (sys_rst) ovr_reg <= 1'b0;
      else if (tick && rx_state_reg == RX_STOP &&
               rx_tick_reg == serial_pkg::OVERSAMPLE && rx_q_full)
         ovr_reg <= 1'b1;
      else if (rx_push) ovr_reg <= 1'b0;
   end

   serial_fifo #(.WIDTH(12), .DEPTH(DEPTH)) u_rxq (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .deep     (line[serial_pkg::LINE_FEN_POS]),
      .push     (rx_push),
      .wdata    ({ovr_reg | rx_entry[11], rx_entry[10:0]}),
      .pop      (rx_pop),
      .rdata    (rx_q_data),
      .empty    (rx_q_empty),
      .full     (rx_q_full)
   );

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         rx_state_reg <= RX_IDLE;
         rx_tick_reg  <= '0;
         rx_bit_reg   <= '0;
         rx_shift_reg <= '0;
         rx_par_reg   <= 1'b0;
         rx_pe_reg    <= 1'b0;
         rx_low_reg   <= 1'b0;
      end else if (tick) begin
         rx_tick_reg <= rx_tick_reg + 4'h1;
         unique case (rx_state_reg)
            RX_IDLE: begin
               rx_tick_reg <= '0;
               if (!rx_in_reg && rx_armed_reg && enable &&
                   ctrl_reg[serial_pkg::CTRL_RXE_POS])
                  rx_state_reg <= RX_START;
            end
            RX_START: if (rx_tick_reg == serial_pkg::MID_TICK) begin
               rx_tick_reg <= '0;
               rx_bit_reg  <= '0;
               rx_par_reg  <= 1'b0;
               rx_low_reg  <= 1'b1;
               rx_shift_reg <= '0;
               rx_state_reg <= rx_in_reg ? RX_IDLE : RX_DATA;
            end
            RX_DATA: if (rx_tick_reg == serial_pkg::OVERSAMPLE) begin
               rx_shift_reg[rx_bit_reg] <= rx_in_reg;
               rx_par_reg <= rx_par_reg ^ rx_in_reg;
               rx_low_reg <= rx_low_reg && !rx_in_reg;
               rx_bit_reg <= rx_bit_reg + 3'h1;
               if (rx_bit_reg == wlen_max)
                  rx_state_reg <= line[serial_pkg::LINE_PEN_POS]
                                  ? RX_PAR : RX_STOP;
            end
            RX_PAR: if (rx_tick_reg == serial_pkg::OVERSAMPLE) begin
               rx_low_reg <= rx_low_reg && !rx_in_reg;
               if (line[serial_pkg::LINE_SPS_POS])
                  rx_pe_reg <= rx_in_reg == line[serial_pkg::LINE_EPS_POS];
               else
                  rx_pe_reg <= rx_par_reg ^ rx_in_reg ^
                               !line[serial_pkg::LINE_EPS_POS];
               rx_state_reg <= RX_STOP;
            end
            RX_STOP: if (rx_tick_reg == serial_pkg::OVERSAMPLE) begin
               rx_pe_reg    <= 1'b0;
               rx_state_reg <= RX_IDLE;
            end
         endcase
      end
   end

   // ---------------- read port ----------------
   always_ff @(posedge core_clk) begin
      if (sys_rst) reg_rdata <= '0;
      else if (reg_rd) begin
         unique case (reg_addr)
            serial_pkg::ADDR_DATA: reg_rdata <= {20'h0, rx_q_data};
            serial_pkg::ADDR_FLAG: reg_rdata <= {24'h0, tx_q_empty,
                  rx_q_full, tx_q_full, rx_q_empty, busy, 3'h0};
            serial_pkg::ADDR_IDIV: reg_rdata <= {16'h0, idiv_reg};
            serial_pkg::ADDR_FDIV: reg_rdata <= {26'h0, fdiv_reg};
            serial_pkg::ADDR_LINE: reg_rdata <= {24'h0, line};
            serial_pkg::ADDR_CTRL: reg_rdata <= {16'h0, ctrl_reg};
            default:               reg_rdata <= '0;
         endcase
      end else reg_rdata <= '0;
   end

   property p_busy_frame;
      @(posedge core_clk) disable iff (sys_rst)
      (tx_state_reg != TX_IDLE) |=> busy;
   endproperty
   a_busy_frame: assert property (p_busy_frame)
      else $error("busy low during frame");

   property p_start_low;
      @(posedge core_clk) disable iff (sys_rst)
      (tx_state_reg == TX_START) |-> !tx_line_reg;
   endproperty
   a_start_low: assert property (p_start_low)
      else $error("start bit not low");

   property p_ctrl_reset;
      @(posedge core_clk)
      $fell(sys_rst) |-> ctrl_reg[serial_pkg::CTRL_TXE_POS] &&
                         ctrl_reg[serial_pkg::CTRL_RXE_POS];
   endproperty
   a_ctrl_reset: assert property (p_ctrl_reset)
      else $error("directions not enabled after reset");

   property p_latch;
      @(posedge core_clk) disable iff (sys_rst)
      !(reg_wr && reg_addr == serial_pkg::ADDR_LINE) |=>
         $stable(active_reg);
   endproperty
   a_latch: assert property (p_latch)
      else $error("divisor changed without line write");

   property p_start_reject;
      @(posedge core_clk) disable iff (sys_rst)
      (tick && rx_state_reg == RX_START && rx_tick_reg ==
       serial_pkg::MID_TICK && rx_in_reg) |=> rx_state_reg == RX_IDLE;
   endproperty
   a_start_reject: assert property (p_start_reject)
      else $error("false start accepted");

   property p_shallow;
      @(posedge core_clk) disable iff (sys_rst)
      (!line[serial_pkg::LINE_FEN_POS] && !tx_q_empty) |-> tx_q_full;
   endproperty
   a_shallow: assert property (p_shallow)
      else $error("queue deeper than one while disabled");

   property p_rd_data;
      @(posedge core_clk) disable iff (sys_rst)
      (reg_rd && reg_addr == serial_pkg::ADDR_DATA) |=>
         reg_rdata[31:12] == 20'h0;
   endproperty
   a_rd_data: assert property (p_rd_data)
      else $error("data read wider than twelve bits");

   property p_fe;
      @(posedge core_clk) disable iff (sys_rst)
      rx_push |-> rx_entry[serial_pkg::ST_FE] ==
                  (!rx_in_reg && !rx_be);
   endproperty
   a_fe: assert property (p_fe)
      else $error("framing flag wrong");
endmodule // serial_core
`default_nettype wire

// ---- hdl/serial_fifo.sv ----
`default_nettype none
module serial_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input  wire logic             core_clk,
   input  wire logic             sys_rst,
   input  wire logic             deep,
   input  wire logic             push,
   input  wire logic [WIDTH-1:0] wdata,
   input  wire logic             pop,
   output logic      [WIDTH-1:0] rdata,
   output logic                  empty,
   output logic                  full
);
   localparam int AW = $clog2(DEPTH);
   initial begin
      if (DEPTH < 2 || (1 << AW) != DEPTH)
         $error("serial_fifo depth must be a power of two");
   end
   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW-1:0]    wp_reg;
   logic [AW-1:0]    rp_reg;
   logic [AW:0]      cnt_reg;
   logic             do_push;
   logic             do_pop;

   // without the queue bit only one entry is usable
   assign empty   = (cnt_reg == '0);
   assign full    = deep ? (cnt_reg == (AW+1)'(DEPTH))
                         : (cnt_reg != '0);
   assign do_push = push && !full;
   assign do_pop  = pop && !empty;
   assign rdata   = mem_reg[rp_reg];

   always_ff @(posedge core_clk) begin
      if (do_push) begin
         mem_reg[wp_reg] <= wdata;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         wp_reg  <= '0;
         rp_reg  <= '0;
         cnt_reg <= '0;
      end else begin
         if (do_push) wp_reg <= wp_reg + 1'b1;
         if (do_pop)  rp_reg <= rp_reg + 1'b1;
         cnt_reg <= cnt_reg + (AW+1)'(do_push) - (AW+1)'(do_pop);
      end
   end
endmodule // serial_fifo
`default_nettype wire

// ---- hdl/serial_pkg.sv ----
`default_nettype none
package serial_pkg;
   // register offsets (byte addresses, one word each)
   localparam logic [7:0] ADDR_DATA   = 8'h00;
   localparam logic [7:0] ADDR_FLAG   = 8'h18;
   localparam logic [7:0] ADDR_IDIV   = 8'h24;
   localparam logic [7:0] ADDR_FDIV   = 8'h28;
   localparam logic [7:0] ADDR_LINE   = 8'h2c;
   localparam logic [7:0] ADDR_CTRL   = 8'h30;
   // control register fields
   localparam int CTRL_EN_POS  = 0;
   localparam int CTRL_IR_POS  = 1;
   localparam int CTRL_TXE_POS = 8;
   localparam int CTRL_RXE_POS = 9;
   localparam logic [15:0] CTRL_RESET = 16'h0300;
   // line control fields
   localparam int LINE_BRK_POS  = 0;
   localparam int LINE_PEN_POS  = 1;
   localparam int LINE_EPS_POS  = 2;
   localparam int LINE_STP2_POS = 3;
   localparam int LINE_FEN_POS  = 4;
   localparam int LINE_WLEN_LSB = 5;
   localparam int LINE_SPS_POS  = 7;
   localparam logic [7:0]  LINE_RESET = 8'h00;
   localparam logic [15:0] IDIV_RESET = 16'h0000;
   localparam logic [5:0]  FDIV_RESET = 6'h00;
   // flag register fields
   localparam int FLAG_BUSY_POS = 3;
   localparam int FLAG_RXFE_POS = 4;
   localparam int FLAG_TXFF_POS = 5;
   localparam int FLAG_RXFF_POS = 6;
   localparam int FLAG_TXFE_POS = 7;
   // receive status positions inside a 12-bit entry
   localparam int ST_FE = 8;
   localparam int ST_PE = 9;
   localparam int ST_BE = 10;
   localparam int ST_OE = 11;
   localparam logic [3:0] OVERSAMPLE = 4'hf;
   localparam logic [3:0] MID_TICK   = 4'h7;
   // infrared pulse: 3 of 16 ticks
   localparam logic [3:0] IR_TICKS   = 4'h3;
   localparam int FIFO_DEPTH = 16;
endpackage : serial_pkg
`default_nettype wire
